// ==== hdl/aor_pkg.sv ====
// package for the adc over-range flag block: register map, field
// layout, reset values and the packed types shared by the design.
// assumes an apb slave of 32-bit data and a 16-bit signed sample stream.
// What this block does
// [RL1] flag a channel when its signed sample goes beyond either threshold
// [RL2] thresholds sit code times 128 inward from both full-scale codes
// [RL3] code zero, the reset value, uses +32767 and -32768 as thresholds
// [RL4] keep the flag asserted for a hold period after the input returns
// [RL5] hold 00 adds 0, 01 adds 3, 10 adds 7, 11 adds 15 cycles
// [RL6] flags only in noise-shaping mode, inactive in resolution-switching
// [RL7] software writes zeros to the six reserved upper hold bits
// [RL8] compare each channel every cycle, restart hold on each new exceed
package aor_pkg;

   // ----------------------------------------------------------------
   // register map (indices; byte address is four times the index)
   // ----------------------------------------------------------------
   localparam logic [7:0] IDX_HOLD_CTRL = 8'h3B;
   localparam logic [7:0] IDX_THRESHOLD = 8'h3C;
   localparam logic [7:0] IDX_MODE_CTRL = 8'h3D;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'h3E;
   localparam logic [7:0] IDX_IRQ_MASK = 8'h3F;
   localparam logic [7:0] IDX_FLAG_STATE = 8'h40;
   localparam int ADDR_LSB = 2;

   // ----------------------------------------------------------------
   // fields and reset values
   // ----------------------------------------------------------------
   localparam int HOLD_W = 2;
   localparam int CODE_W = 8;
   localparam int CNT_W = 4;
   localparam logic [HOLD_W-1:0] HOLD_RST = 2'h0;
   localparam logic [CODE_W-1:0] CODE_RST = 8'h00;
   localparam logic MODE_RST = 1'b1;
   localparam int CODE_SHIFT = 7;
   localparam logic signed [16:0] FS_HIGH = 17'sh07FFF;
   localparam logic signed [16:0] FS_LOW = -17'sh08000;
   localparam logic [CNT_W-1:0] EXT_0 = 4'h0;
   localparam logic [CNT_W-1:0] EXT_1 = 4'h3;
   localparam logic [CNT_W-1:0] EXT_2 = 4'h7;
   localparam logic [CNT_W-1:0] EXT_3 = 4'hF;

   typedef enum logic [0:0] {
      MODE_BURST = 1'b0,
      MODE_NOISE_SHAPE = 1'b1
   } aor_mode_type;

   // per-channel stretch state
   typedef struct packed {
      logic flag;
      logic [CNT_W-1:0] count;
   } aor_chan_type;

   // one register-bus access as seen by the decode
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] idx;
      logic [31:0] data;
   } aor_acc_type;

endpackage

// ==== hdl/adc_over_range_detector.sv ====
// over-range flag generator for two adc channels with apb registers.
// assumes samples arrive on every ref_clk edge, synchronous to ref_clk,
// and a standard apb master on the same clock.
//
// Chosen here: the APB slave port.
module adc_over_range_detector #(
   parameter int SAMPLE_W = 16,
   parameter int CHANNELS = 2
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic signed [SAMPLE_W-1:0] sampleA,
   input wire logic signed [SAMPLE_W-1:0] sampleB,
   output logic [CHANNELS-1:0] over_range_flag,
   output logic irq
);

   // ----------------------------------------------------------------
   // functions
   // ----------------------------------------------------------------
   function automatic logic [aor_pkg::CNT_W-1:0] holdLen(
      input logic [aor_pkg::HOLD_W-1:0] sel);
      logic [aor_pkg::CNT_W-1:0] len;
      len = aor_pkg::EXT_0;
      unique case (sel)
         2'h0: len = aor_pkg::EXT_0;
         2'h1: len = aor_pkg::EXT_1;
         2'h2: len = aor_pkg::EXT_2;
         2'h3: len = aor_pkg::EXT_3;
      endcase
      return len;
   endfunction

   // reaching a threshold counts as beyond it, so a clipped sample
   // still flags at code zero where nothing can pass full scale
   function automatic logic beyond(
      input logic signed [SAMPLE_W-1:0] s,
      input logic signed [16:0] hi,
      input logic signed [16:0] lo);
      logic signed [16:0] wide;
      wide = 17'(s);
      return (wide >= hi) || (wide <= lo);
   endfunction

   function automatic aor_pkg::aor_chan_type stepChan(
      input aor_pkg::aor_chan_type cur,
      input logic hit,
      input logic active,
      input logic [aor_pkg::CNT_W-1:0] len);
      aor_pkg::aor_chan_type nxt;
      nxt = cur;
      if (!active) begin
         nxt.flag = 1'b0;
         nxt.count = '0;
      end else if (hit) begin
         nxt.flag = 1'b1;
         nxt.count = len;
      end else if (cur.count != '0) begin
         nxt.flag = 1'b1;
         nxt.count = cur.count - 1'b1;
      end else begin
         nxt.flag = 1'b0;
      end
      return nxt;
   endfunction

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic [aor_pkg::HOLD_W-1:0] flag_stretch_select;
   logic [aor_pkg::CODE_W-1:0] full_scale_margin_code;
   aor_pkg::aor_mode_type mode;
   logic [CHANNELS-1:0] irqStatus;
   logic [CHANNELS-1:0] irqMask;
   aor_pkg::aor_chan_type chanA;
   aor_pkg::aor_chan_type chanB;

   // ----------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------
   aor_pkg::aor_acc_type acc;
   wire logic accessEdge;
   wire logic mapped;
   wire logic [31:0] readMux;
   wire logic [CHANNELS-1:0] flagRise;
   wire logic [CHANNELS-1:0] statusClear;
   wire logic [CHANNELS-1:0] next_irqStatus;
   wire logic [CHANNELS-1:0] next_irqMask;

   assign accessEdge = psel && penable && pready;
   assign acc.idx = paddr[aor_pkg::ADDR_LSB+7:aor_pkg::ADDR_LSB];
   assign acc.wr = accessEdge && pwrite;
   assign acc.rd = accessEdge && !pwrite;
   assign acc.data = pwdata;
   assign mapped = (acc.idx == aor_pkg::IDX_HOLD_CTRL)
      || (acc.idx == aor_pkg::IDX_THRESHOLD)
      || (acc.idx == aor_pkg::IDX_MODE_CTRL)
      || (acc.idx == aor_pkg::IDX_IRQ_STATUS)
      || (acc.idx == aor_pkg::IDX_IRQ_MASK)
      || (acc.idx == aor_pkg::IDX_FLAG_STATE);

   // reserved hold bits are not stored and read back as zero
   assign readMux =
      (acc.idx == aor_pkg::IDX_HOLD_CTRL) ? 32'(flag_stretch_select) :
      (acc.idx == aor_pkg::IDX_THRESHOLD) ? 32'(full_scale_margin_code) :
      (acc.idx == aor_pkg::IDX_MODE_CTRL) ? 32'(mode) :
      (acc.idx == aor_pkg::IDX_IRQ_STATUS) ? 32'(irqStatus) :
      (acc.idx == aor_pkg::IDX_IRQ_MASK) ? 32'(irqMask) :
      (acc.idx == aor_pkg::IDX_FLAG_STATE) ? 32'(over_range_flag) :
      32'h0000_0000;

   // one wait-free access phase: ready follows the setup cycle
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         prdata <= (psel && !penable && !pwrite) ? readMux : 32'h0000_0000;
         pslverr <= psel && !penable && !mapped;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         flag_stretch_select <= aor_pkg::HOLD_RST;
         full_scale_margin_code <= aor_pkg::CODE_RST;
         mode <= aor_pkg::aor_mode_type'(aor_pkg::MODE_RST);
         irqMask <= '0;
      end else if (acc.wr) begin
         if (acc.idx == aor_pkg::IDX_HOLD_CTRL)
            flag_stretch_select <= acc.data[aor_pkg::HOLD_W-1:0]; // RL7
         if (acc.idx == aor_pkg::IDX_THRESHOLD)
            full_scale_margin_code <= acc.data[aor_pkg::CODE_W-1:0];
         if (acc.idx == aor_pkg::IDX_MODE_CTRL)
            mode <= aor_pkg::aor_mode_type'(acc.data[0]);
         if (acc.idx == aor_pkg::IDX_IRQ_MASK)
            irqMask <= acc.data[CHANNELS-1:0];
      end
   end

   // ----------------------------------------------------------------
   // thresholds
   // ----------------------------------------------------------------
   wire logic signed [16:0] margin;
   wire logic signed [16:0] thHigh;
   wire logic signed [16:0] thLow;
   wire logic active;
   wire logic [aor_pkg::CNT_W-1:0] len;
   wire logic hitA;
   wire logic hitB;

   assign margin = 17'(full_scale_margin_code) <<< aor_pkg::CODE_SHIFT;
   assign thHigh = aor_pkg::FS_HIGH - margin; // RL2 RL3
   assign thLow = aor_pkg::FS_LOW + margin; // RL2 RL3
   assign active = (mode == aor_pkg::MODE_NOISE_SHAPE); // RL6
   assign len = holdLen(flag_stretch_select); // RL5
   assign hitA = beyond(sampleA, thHigh, thLow); // RL1 RL8
   assign hitB = beyond(sampleB, thHigh, thLow); // RL1 RL8

   // ----------------------------------------------------------------
   // stretch and flags
   // ----------------------------------------------------------------
   aor_pkg::aor_chan_type next_chanA;
   aor_pkg::aor_chan_type next_chanB;

   assign next_chanA = stepChan(chanA, hitA, active, len); // RL4 RL8
   assign next_chanB = stepChan(chanB, hitB, active, len); // RL4 RL8

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         chanA <= '0;
         chanB <= '0;
      end else begin
         chanA <= next_chanA;
         chanB <= next_chanB;
      end
   end

   assign over_range_flag = {chanB.flag, chanA.flag};

   // ----------------------------------------------------------------
   // interrupts
   // ----------------------------------------------------------------
   // a new over-range episode is the event; set beats a clearing write
   assign flagRise = {next_chanB.flag & ~chanB.flag,
      next_chanA.flag & ~chanA.flag};
   assign statusClear = (acc.wr && acc.idx == aor_pkg::IDX_IRQ_STATUS)
      ? acc.data[CHANNELS-1:0] : '0;
   assign next_irqStatus = (irqStatus & ~statusClear) | flagRise;
   // a mask write counts at once, so irq never lags status and mask
   assign next_irqMask = (acc.wr && acc.idx == aor_pkg::IDX_IRQ_MASK)
      ? acc.data[CHANNELS-1:0] : irqMask;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         irqStatus <= '0;
         irq <= 1'b0;
      end else begin
         irqStatus <= next_irqStatus;
         irq <= |(next_irqStatus & next_irqMask);
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);

   a_flag_on_hit: assert property ( // RL1
      active && hitA && $stable(mode) |=> over_range_flag[0])
      else $error("flag A not raised after exceeding sample");

   a_threshold_place: assert property ( // RL2
      thHigh == 17'sd32767 - 17'sd128 * 17'(full_scale_margin_code)
      && thLow == -17'sd32768 + 17'sd128 * 17'(full_scale_margin_code))
      else $error("thresholds not placed inward by code times 128");

   a_full_scale_zero: assert property ( // RL3
      full_scale_margin_code == 8'h00 |->
      thHigh == 17'sd32767 && thLow == -17'sd32768)
      else $error("code zero does not give full-scale thresholds");

   a_hold_three: assert property ( // RL4
      active && hitB && flag_stretch_select == 2'h1
      ##1 (!hitB && active && $stable(flag_stretch_select)) [*3]
      |-> over_range_flag[1])
      else $error("flag B dropped before three-cycle hold ended");

   a_hold_ends: assert property ( // RL5
      active && hitA && flag_stretch_select == 2'h2
      ##1 (!hitA && active && $stable(flag_stretch_select)) [*8]
      |=> !over_range_flag[0])
      else $error("flag A held beyond seven extra cycles");

   a_hold_none: assert property ( // RL5
      active && hitA && flag_stretch_select == 2'h0
      ##1 (!hitA && active && $stable(flag_stretch_select))
      |=> !over_range_flag[0])
      else $error("flag A stretched with hold set to zero");

   a_burst_quiet: assert property ( // RL6
      mode == aor_pkg::MODE_BURST |=> over_range_flag == '0)
      else $error("flag active in resolution-switching mode");

   a_restart_hold: assert property ( // RL8
      active && hitB && $stable(mode) |=> chanB.count == $past(len))
      else $error("hold countdown not restarted on new exceed");

   a_irq_level: assert property (
      |(irqStatus & irqMask) |-> irq || $past(statusClear) != '0
      || $rose(|(irqStatus & irqMask)))
      else $error("interrupt low with unmasked status set");

   a_write_lands: assert property (
      acc.wr && acc.idx == aor_pkg::IDX_THRESHOLD
      |=> full_scale_margin_code == $past(pwdata[7:0]))
      else $error("threshold write did not take effect");

   a_hit_raises_b: assert property ( // RL1
      active && hitB |=> over_range_flag[1])
      else $error("flag B not raised after exceeding sample");

   a_rise_needs_hit: assert property ( // RL1
      $rose(over_range_flag[0]) |-> $past(hitA) && $past(active))
      else $error("flag A raised without an exceeding sample");

   a_restart_a: assert property ( // RL8
      active && hitA |=> chanA.count == $past(len))
      else $error("hold countdown of A not reloaded");

   a_count_dec_a: assert property ( // RL4
      active && !hitA && chanA.count != '0
      |=> over_range_flag[0] && chanA.count == $past(chanA.count) - 4'h1)
      else $error("hold countdown of A not running down");

   a_drop_a: assert property ( // RL4
      active && !hitA && chanA.count == '0 |=> !over_range_flag[0])
      else $error("flag A kept after hold ran out");

   a_count_dec_b: assert property ( // RL4
      active && !hitB && chanB.count != '0
      |=> over_range_flag[1] && chanB.count == $past(chanB.count) - 4'h1)
      else $error("hold countdown of B not running down");

   a_drop_b: assert property ( // RL4
      active && !hitB && chanB.count == '0 |=> !over_range_flag[1])
      else $error("flag B kept after hold ran out");

   a_burst_count: assert property ( // RL6
      !active |=> chanA.count == '0 && chanB.count == '0)
      else $error("hold countdown running in resolution-switching mode");

   a_long_hold: assert property ( // RL5
      flag_stretch_select == 2'h3 |-> len == 4'hF)
      else $error("hold code 11 does not give fifteen cycles");

   a_hold_write: assert property (
      acc.wr && acc.idx == aor_pkg::IDX_HOLD_CTRL
      |=> flag_stretch_select == $past(pwdata[1:0]))
      else $error("hold write did not take effect");

   a_mask_write: assert property (
      acc.wr && acc.idx == aor_pkg::IDX_IRQ_MASK
      |=> irqMask == $past(pwdata[1:0]))
      else $error("mask write did not take effect");

   a_ready_after_setup: assert property (
      psel && !penable |=> pready)
      else $error("no access phase ready after setup");

   a_ready_one_cycle: assert property (
      pready |=> !pready)
      else $error("ready stood longer than one cycle");

   a_err_unmapped: assert property (
      psel && !penable && !mapped |=> pslverr)
      else $error("no error response for unmapped index");

   a_rdata_idle: assert property (
      !pready |-> prdata == 32'h0000_0000)
      else $error("read data not zero outside access phase");

   a_set_beats_clear: assert property (
      flagRise[1] |=> irqStatus[1])
      else $error("status B not set on new over-range episode");

   a_status_clear: assert property (
      statusClear[0] && !flagRise[0] |=> !irqStatus[0])
      else $error("status A not cleared by writing one");

   a_irq_tracks: assert property (
      irq == |(irqStatus & irqMask))
      else $error("interrupt differs from unmasked status");

endmodule

// ==== verif/aor_flag_sink.sv ====
// host-side model of the logic that watches the two over-range flags.
// assumes the flags are registered levels on ref_clk.
module aor_flag_sink (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [1:0] flags,
   output logic [7:0] runA,
   output logic [7:0] runB
);
   logic [7:0] cntA;
   logic [7:0] cntB;

   // length of the last finished high run, captured when the flag drops
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cntA <= 8'h00;
         cntB <= 8'h00;
         runA <= 8'h00;
         runB <= 8'h00;
      end else begin
         cntA <= flags[0] ? cntA + 8'h01 : 8'h00;
         cntB <= flags[1] ? cntB + 8'h01 : 8'h00;
         if (!flags[0] && cntA != 8'h00) runA <= cntA;
         if (!flags[1] && cntB != 8'h00) runB <= cntB;
      end
   end
endmodule

// ==== verif/adc_over_range_detector_tb.sv ====
// self-checking bench for the over-range flag block.
// assumes nothing of the apb wait states; a stuck bus ends in the timeout.
module adc_over_range_detector_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, irq, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdv, lfsr;
   logic signed [15:0] sampleA, sampleB;
   logic [1:0] flags;
   logic [7:0] runA, runB, code;
   logic [7:0] corner [4] = '{8'h00, 8'h01, 8'h80, 8'hFF};
   int miscompares, totalChecks, cycles, hi;

   adc_over_range_detector i_adc_over_range_detector (.ref_clk(ref_clk),
      .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sampleA(sampleA), .sampleB(sampleB),
      .over_range_flag(flags), .irq(irq));
   aor_flag_sink i_aor_flag_sink (.ref_clk(ref_clk), .rst_n(rst_n),
      .flags(flags), .runA(runA), .runB(runB));

   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end

   // ----------------------------------------------------------------
   // expectations and bus tasks
   // ----------------------------------------------------------------
   function automatic logic [31:0] nextRand(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction

   function automatic logic beyond(input logic signed [15:0] s,
                                   input logic [7:0] cd);
      int c;
      c = cd;
      return (s >= 32767 - c * 128) || (s <= -32768 + c * 128);
   endfunction

   function automatic int extOf(input int sel);
      return (sel == 0) ? 0 : (2 << sel) - 1;
   endfunction

   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      totalChecks++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   // request held until the edge that samples pready high
   task automatic apb(input logic w, input logic [7:0] idx,
                      input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {2'h0, idx, 2'h0};
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      rdv = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rdchk(input string what, input logic [7:0] idx,
                        input logic [31:0] exp);
      apb(1'b0, idx, 32'h0);
      chk(what, exp, rdv);
   endtask

   task automatic put(input logic signed [15:0] a,
                      input logic signed [15:0] b);
      @(posedge ref_clk);
      sampleA <= a;
      sampleB <= b;
   endtask

   task automatic step(input logic signed [15:0] a,
                       input logic signed [15:0] b, input logic en);
      put(a, b);
      @(posedge ref_clk);
      @(negedge ref_clk);
      chk("flags", {30'h0, {beyond(b, code), beyond(a, code)} & {2{en}}},
          {30'h0, flags});
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", totalChecks, miscompares);
      if (miscompares == 0 && totalChecks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         close_out();
      end
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
      sampleA = 16'sh0000;
      sampleB = 16'sh0000;
      lfsr = 32'h4381;
      code = 8'h00;
      repeat (5) @(posedge ref_clk);
      rst_n <= 1'b1;
      rdchk("hold", aor_pkg::IDX_HOLD_CTRL, 32'h0);
      rdchk("code", aor_pkg::IDX_THRESHOLD, 32'h0);
      rdchk("mode", aor_pkg::IDX_MODE_CTRL, 32'h1);
      rdchk("mask", aor_pkg::IDX_IRQ_MASK, 32'h0);
      rdchk("unmapped", 8'h10, 32'h0);
      chk("slverr", 32'h1, {31'h0, err});
      // corner codes first, then random ones, with no stretch
      for (int i = 0; i < 24; i++) begin
         lfsr = nextRand(lfsr);
         code = (i < 4) ? corner[i] : lfsr[7:0];
         apb(1'b1, aor_pkg::IDX_THRESHOLD, {24'h0, code});
         hi = 32767 - int'(code) * 128;
         for (int j = 0; j < 4; j++) begin
            lfsr = nextRand(lfsr);
            step(j == 3 ? lfsr[15:0] : 16'(hi - lfsr[0]),
                 16'(-hi - 1 + lfsr[1]), 1'b1);
         end
      end
      code = 8'h00;
      apb(1'b1, aor_pkg::IDX_THRESHOLD, 32'h0);
      apb(1'b1, aor_pkg::IDX_IRQ_MASK, 32'h3);
      for (int s = 0; s < 4; s++) begin
         apb(1'b1, aor_pkg::IDX_HOLD_CTRL, s);
         rdchk("hold", aor_pkg::IDX_HOLD_CTRL, s);
         put(16'sh7FFF, 16'sh8000);
         put(16'sh7FFF, 16'sh0000);
         put(16'sh0000, 16'sh8000);
         put(16'sh0000, 16'sh0000);
         repeat (20) @(posedge ref_clk);
         chk("runA", 2 + extOf(s), {24'h0, runA});
         chk("runB", s == 0 ? 1 : 3 + extOf(s), {24'h0, runB});
      end
      chk("irq", 32'h1, {31'h0, irq});
      rdchk("status", aor_pkg::IDX_IRQ_STATUS, 32'h3);
      apb(1'b1, aor_pkg::IDX_IRQ_MASK, 32'h0);
      apb(1'b1, aor_pkg::IDX_IRQ_STATUS, 32'h3);
      step(16'sh7FFF, 16'sh0000, 1'b1);
      chk("masked irq", 32'h0, {31'h0, irq});
      rdchk("flag state", aor_pkg::IDX_FLAG_STATE, 32'h1);
      chk("mapped slverr", 32'h0, {31'h0, err});
      apb(1'b1, aor_pkg::IDX_IRQ_MASK, 32'h1);
      @(negedge ref_clk);
      chk("unmasked irq", 32'h1, {31'h0, irq});
      apb(1'b1, aor_pkg::IDX_IRQ_STATUS, 32'h3);
      apb(1'b1, aor_pkg::IDX_MODE_CTRL, 32'h0);
      for (int k = 0; k < 4; k++) step(16'sh7FFF, 16'sh8000, 1'b0);
      rdchk("status", aor_pkg::IDX_IRQ_STATUS, 32'h0);
      close_out();
   end
endmodule
